// ### dv/isc_bus_model.sv
// behavioural two-wire bus master facing one slave port; outputs 1 = released
`timescale 1ns/1ps
module isc_bus_model (
  input wire logic clk,
  input wire logic sdaLine,
  output logic sclDrv = 1'b1,
  output logic sdaDrv = 1'b1
);
  // data moves only while scl is low, so no false start or stop is seen
  task automatic lowHalf(input logic b, input int h);
    sdaDrv <= b;
    repeat (h) @(posedge clk);
    sclDrv <= 1'b1;
  endtask
  task automatic highHalf(input int h, output logic r);
    repeat (h) @(posedge clk);
    r = sdaLine;
    sclDrv <= 1'b0;
  endtask
  task automatic seq(input logic [8:0] d, input int nb, input int h, output logic [8:0] q);
    logic r;
    q = 9'h000;
    for (int i = 8; i > 8 - nb; i--) begin
      lowHalf(d[i], h);
      highHalf(h, r);
      q[i] = r;
    end
  endtask
  task automatic start(input int h);
    sdaDrv <= 1'b0;
    repeat (h) @(posedge clk);
    sclDrv <= 1'b0;
  endtask
  task automatic stop(input int h);
    sdaDrv <= 1'b0;
    repeat (h) @(posedge clk);
    sclDrv <= 1'b1;
    repeat (h) @(posedge clk);
    sdaDrv <= 1'b1;
  endtask
endmodule // isc_bus_model

// ### dv/isc_ctrl_monitor.sv
// checker on the controller pair ports: bus answers, register shadows, scl and irq
`timescale 1ns/1ps
`include "isc_defines.vh"
module isc_ctrl_monitor #(
  parameter NPORT = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NPORT-1:0] sclOut,
  input wire logic [NPORT-1:0] sclOe_b,
  input wire logic [NPORT-1:0] sdaOut,
  input wire logic [NPORT-1:0] irq
);
  logic [15:0] div0Reg, ctl1Reg;
  logic en0Reg;
  logic [8:0] lowReg;
  wire rdAck = wb_ack_o && !wb_we_i;
  // bit 7 is left out of the shadow: hardware clears it after one byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div0Reg <= 16'h1f1f;
      ctl1Reg <= 16'h0000;
      en0Reg <= 1'b0;
    end else if (wb_ack_o && wb_we_i) begin
      if (wb_adr_i == `ISC_P0_SCL_DIVIDER) div0Reg <= wb_dat_i[15:0];
      if (wb_adr_i == `ISC_P1_SLAVE_CONTROL) ctl1Reg <= wb_dat_i[15:0] & 16'h0720;
      if (wb_adr_i == `ISC_P0_SLAVE_AUX) en0Reg <= wb_dat_i[7];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lowReg <= 9'h000;
    else lowReg <= sclOe_b[0] ? 9'h000 : lowReg + 9'h001;
  end
  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rst_b);
  bus_ack_pulse_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  unmapped_zero_a: assert property (
    rdAck && wb_adr_i[31:12] != 20'hffff0 |-> wb_dat_o == 32'h0) else $error("unmapped read");
  ctl_readback_a: assert property (
    rdAck && wb_adr_i == `ISC_P1_SLAVE_CONTROL |-> (wb_dat_o & 32'hffffff7f) == {16'h0, ctl1Reg})
    else $error("control readback");
  div_readback_a: assert property (
    rdAck && wb_adr_i == `ISC_P0_SCL_DIVIDER |-> wb_dat_o == {16'h0, div0Reg})
    else $error("divider readback");
  irq_gated_a: assert property (
    irq[1] |-> ctl1Reg[10:8] != 3'b000) else $error("irq without enable");
  scl_low_len_a: assert property (
    $rose(sclOe_b[0]) && en0Reg |-> lowReg == {1'b0, div0Reg[7:0]} + 9'h001)
    else $error("scl low length");
  scl_idle_a: assert property (
    !en0Reg && !$past(en0Reg) |-> sclOe_b[0]) else $error("scl driven while master off");
  open_drain_a: assert property (
    sclOut == '0 && sdaOut == '0) else $error("line driven high");
endmodule // isc_ctrl_monitor
bind isc_ctrl_top isc_ctrl_monitor #(.NPORT(NPORT)) mon (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclOut(sclOut),
  .sclOe_b(sclOe_b), .sdaOut(sdaOut), .irq(irq));

// ### dv/test_i2c_scl_divider_slave_control.sv
// self-checking bench: registers, master scl timing, slave traffic on port 1
`timescale 1ns/1ps
`include "isc_defines.vh"
module test_i2c_scl_divider_slave_control;
  localparam logic [31:0] D0 = `ISC_P0_SCL_DIVIDER, A0 = `ISC_P0_SLAVE_AUX;
  localparam logic [31:0] D1 = `ISC_P1_SCL_DIVIDER, C1 = `ISC_P1_SLAVE_CONTROL;
  localparam logic [31:0] A1 = `ISC_P1_SLAVE_AUX, S1 = `ISC_P1_SLAVE_STATUS;
  logic clk, rst_b, cyc, stb, we;
  logic [31:0] adr, dat;
  logic [3:0] sel;
  wire [31:0] datO;
  wire ack, sclM, sdaM;
  wire [1:0] sclOut, sclOe_b, sdaOut, sdaOe_b, irq;
  int nErrors = 0;
  int testsRun = 0;
  // pull-ups on every line; port 0 has no other party
  wire [1:0] sclIn = {sclM & (sclOe_b[1] | sclOut[1]), sclOe_b[0] | sclOut[0]};
  wire [1:0] sdaIn = {sdaM & (sdaOe_b[1] | sdaOut[1]), sdaOe_b[0] | sdaOut[0]};
  isc_ctrl_top uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .sclIn(sclIn), .sclOut(sclOut), .sclOe_b(sclOe_b), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe_b(sdaOe_b), .irq(irq));
  isc_bus_model m (.clk(clk), .sdaLine(sdaIn[1]), .sclDrv(sclM), .sdaDrv(sdaM));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) begin
      nErrors++;
      $display("mismatch at %0t: no bus acknowledge", $time);
    end
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'h3, q);
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'h3, q);
    chk(q & m, e);
  endtask
  task automatic tRegs;
    logic [31:0] q;
    rdChk(D0, '1, 32'h1f1f);
    rdChk(D1, '1, 32'h1f1f);
    rdChk(C1, '1, 32'h0);
    wr(C1, 32'h07a0);
    rdChk(C1, '1, 32'h07a0);
    chk(irq, 2'b00);
    wr(D1, 32'h1234);
    rdChk(D1, '1, 32'h1234);
    wb(1'b1, D1, 32'h00ff, 4'h1, q);
    rdChk(D1, '1, 32'h12ff);
    wr(32'h10, 32'hffff);
    rdChk(32'h10, '1, 32'h0);
  endtask
  task automatic span(input logic v, output int n);
    n = 0;
    while (sclOe_b[0] === v && n < 600) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic tClock(input logic [15:0] dv);
    int n, hi, lo;
    wr(D0, {16'h0, dv});
    wr(A0, 32'h80);
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, hi);
    span(1'b0, lo);
    chk(hi, dv[15:8] + 1);
    chk(lo, dv[7:0] + 1);
    wr(A0, 32'h0);
  endtask
  task automatic tWrite;
    logic [8:0] q;
    wr(A1, 32'h2a);
    wr(C1, 32'h0200);
    m.start(8);
    m.seq({7'h2a, 2'b01}, 9, 8, q);
    chk(q[0], 1'b0);
    m.seq({8'ha5, 1'b1}, 9, 8, q);
    chk(q[0], 1'b0);
    chk(irq[1], 1'b1);
    rdChk(S1, 32'hff0f, 32'ha502);
    wr(C1, 32'h0080);
    chk(irq[1], 1'b0);
    m.seq({8'h5a, 1'b1}, 9, 8, q);
    chk(q[0], 1'b1);
    m.seq({8'hc3, 1'b1}, 9, 8, q);
    chk(q[0], 1'b0);
    rdChk(C1, '1, 32'h0);
    wr(S1, 32'hf);
    wr(C1, 32'h0100);
    m.stop(8);
    repeat (4) @(posedge clk);
    chk(irq[1], 1'b1);
    wr(S1, 32'hf);
    chk(irq[1], 1'b0);
  endtask
  task automatic tRead(input logic e);
    logic [8:0] q;
    logic r;
    wr(A1, 32'h3c2a);
    wr(C1, e ? 32'h0420 : 32'h0400);
    wr(S1, 32'hf);
    m.start(20);
    m.seq({7'h2a, 2'b11}, 7, 20, q);
    m.lowHalf(1'b1, 20);
    repeat (6) @(posedge clk);
    chk(irq[1], e);
    m.highHalf(14, r);
    repeat (6) @(posedge clk);
    chk(irq[1], 1'b1);
    m.seq(9'h1ff, 1, 20, q);
    chk(q[8], 1'b0);
    m.seq(9'h1fe, 9, 20, q);
    chk(q[8:1], 8'h3c);
    m.seq(9'h1ff, 9, 20, q);
    chk(q[8:1], 8'h3c);
    rdChk(S1, 32'h1, 32'h1);
    wr(S1, 32'h8);
    chk(irq[1], 1'b1);
    m.stop(20);
    wr(C1, 32'h0);
    chk(irq[1], 1'b0);
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    testDone();
  end
  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, adr, dat, sel} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    tRegs();
    tClock(16'h0305);
    tClock(16'h0a02);
    tWrite();
    tRead(1'b0);
    tRead(1'b1);
    testDone();
  end
endmodule // test_i2c_scl_divider_slave_control

// ### hdl/isc_ctrl_top.v
// two two-wire controller ports: wishbone registers, clock generators and slave engines
// Notes on behaviour
// - as master, drive scl at a rate set by the divider register
// - divider bits 15:8 set the scl high time
// - divider bits 7:0 set the scl low time
// - control bit 10 enables the slave byte-sent interrupt
// - control bit 9 enables the slave data-received interrupt
// - control bit 8 enables the stop-detected interrupt
// - control bit 7 makes the slave not-acknowledge the next byte
// - with bit 7 clear, hardware alone decides acknowledge
// - bit 5 set: transmit request right after scl rise of the read bit
// - bit 5 clear: transmit request right after scl fall of the read bit
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "isc_defines.vh"
module isc_ctrl_top #(
  parameter NPORT = 2
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [NPORT-1:0] sclIn,
  output wire [NPORT-1:0] sclOut,
  output wire [NPORT-1:0] sclOe_b,
  input wire [NPORT-1:0] sdaIn,
  output wire [NPORT-1:0] sdaOut,
  output wire [NPORT-1:0] sdaOe_b,
  output wire [NPORT-1:0] irq
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACK = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_TX = 3'd4;
  localparam S_MACK = 3'd5;

  wire req = wb_cyc_i & wb_stb_i;
  // writes land at the edge where the master sees ack, never earlier
  wire wrNow = req & wb_we_i & wb_ack_o;
  // sel[0] guards bits 7:0 and sel[1] bits 15:8; the upper lanes have no storage
  wire [15:0] wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] rdPort [0:NPORT-1];

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : gPort
      wire [31:0] aDiv = (p == 0) ? `ISC_P0_SCL_DIVIDER : `ISC_P1_SCL_DIVIDER;
      wire [31:0] aCtl = (p == 0) ? `ISC_P0_SLAVE_CONTROL : `ISC_P1_SLAVE_CONTROL;
      wire [31:0] aAux = (p == 0) ? `ISC_P0_SLAVE_AUX : `ISC_P1_SLAVE_AUX;
      wire [31:0] aSta = (p == 0) ? `ISC_P0_SLAVE_STATUS : `ISC_P1_SLAVE_STATUS;

      reg [15:0] sclDivider_reg;
      reg [15:0] slaveControl_reg;
      reg [15:0] slaveAux_reg;
      reg [3:0] flags_reg;
      reg [7:0] rxData_reg;
      reg [2:0] state_reg;
      reg [3:0] bitCnt_reg;
      reg [7:0] shift_reg;
      reg rwBit_reg;
      reg sdaLow_reg;
      reg masterAck_reg;
      reg sclPrev_reg;
      reg sdaPrev_reg;
      reg txDonePulse;
      reg rxDonePulse;
      reg stopPulse;
      reg txReqPulse;
      reg nakUsedPulse;
      reg [31:0] rdData;

      wire txIrqEn = slaveControl_reg[`ISC_SCTL_TX_IRQ_EN];
      wire rxIrqEn = slaveControl_reg[`ISC_SCTL_RX_IRQ_EN];
      wire stopIrqEn = slaveControl_reg[`ISC_SCTL_STOP_IRQ_EN];
      wire forceNotAck = slaveControl_reg[`ISC_SCTL_FORCE_NOT_ACK];
      wire earlyTxReq = slaveControl_reg[`ISC_SCTL_EARLY_TX_REQ];
      wire [6:0] ownAddr = slaveAux_reg[`ISC_AUX_ADDR_MSB:0];
      wire [7:0] txData = slaveAux_reg[`ISC_AUX_TXDATA_MSB:`ISC_AUX_TXDATA_LSB];
      wire sclRise = sclIn[p] & ~sclPrev_reg;
      wire sclFall = ~sclIn[p] & sclPrev_reg;
      wire startCond = sclIn[p] & sclPrev_reg & sdaPrev_reg & ~sdaIn[p];
      wire stopCond = sclIn[p] & sclPrev_reg & ~sdaPrev_reg & sdaIn[p];
      wire addrHit = (shift_reg[6:0] == ownAddr);
      wire sclLow;
      wire [3:0] setFlags = {txReqPulse, stopPulse, rxDonePulse, txDonePulse};

      isc_scl_gen #(
        .CW(8)
      ) uSclGen (
        .clk(clk),
        .rst_b(rst_b),
        .enable(slaveAux_reg[`ISC_AUX_MASTER_EN]),
        .highCount(sclDivider_reg[`ISC_DIV_HIGH_MSB:`ISC_DIV_HIGH_LSB]),
        .lowCount(sclDivider_reg[`ISC_DIV_LOW_MSB:`ISC_DIV_LOW_LSB]),
        .sclIn(sclIn[p]),
        .sclDriveLow(sclLow)
      );

      assign sclOut[p] = 1'b0;
      assign sclOe_b[p] = ~sclLow;
      assign sdaOut[p] = 1'b0;
      assign sdaOe_b[p] = ~sdaLow_reg;
      assign irq[p] = (flags_reg[`ISC_STA_TX_DONE] & txIrqEn) |
        (flags_reg[`ISC_STA_TX_REQ] & txIrqEn) |
        (flags_reg[`ISC_STA_RX_DONE] & rxIrqEn) |
        (flags_reg[`ISC_STA_STOP] & stopIrqEn);

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sclDivider_reg <= `ISC_DIV_RESET;
          slaveControl_reg <= `ISC_SCTL_RESET;
          slaveAux_reg <= `ISC_AUX_RESET;
          flags_reg <= 4'h0;
        end else begin
          if (wrNow && wb_adr_i == aDiv) begin
            sclDivider_reg <= (sclDivider_reg & ~wrMask) | (wb_dat_i[15:0] & wrMask);
          end
          // reserved control bits are not stored and read back as zero
          if (wrNow && wb_adr_i == aCtl) begin
            slaveControl_reg <= ((slaveControl_reg & ~wrMask) | (wb_dat_i[15:0] & wrMask))
              & `ISC_SCTL_MASK;
          end else if (nakUsedPulse) begin
            slaveControl_reg[`ISC_SCTL_FORCE_NOT_ACK] <= 1'b0;
          end
          if (wrNow && wb_adr_i == aAux) begin
            slaveAux_reg <= (slaveAux_reg & ~wrMask) | (wb_dat_i[15:0] & wrMask);
          end
          // write one to clear; a new event in the same cycle wins
          if (wrNow && wb_adr_i == aSta && wb_sel_i[0]) begin
            flags_reg <= (flags_reg & ~wb_dat_i[3:0]) | setFlags;
          end else begin
            flags_reg <= flags_reg | setFlags;
          end
        end
      end

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          state_reg <= S_IDLE;
          bitCnt_reg <= 4'h0;
          shift_reg <= 8'h00;
          rwBit_reg <= 1'b0;
          sdaLow_reg <= 1'b0;
          masterAck_reg <= 1'b0;
          // previous samples start at the idle-high level so no false edge follows reset
          sclPrev_reg <= 1'b1;
          sdaPrev_reg <= 1'b1;
          rxData_reg <= 8'h00;
          txDonePulse <= 1'b0;
          rxDonePulse <= 1'b0;
          stopPulse <= 1'b0;
          txReqPulse <= 1'b0;
          nakUsedPulse <= 1'b0;
        end else begin
          sclPrev_reg <= sclIn[p];
          sdaPrev_reg <= sdaIn[p];
          txDonePulse <= 1'b0;
          rxDonePulse <= 1'b0;
          stopPulse <= 1'b0;
          txReqPulse <= 1'b0;
          nakUsedPulse <= 1'b0;
          if (stopCond) begin
            stopPulse <= 1'b1;
            state_reg <= S_IDLE;
            sdaLow_reg <= 1'b0;
          end else if (startCond) begin
            state_reg <= S_ADDR;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= 1'b0;
          end else begin
            case (state_reg)
              S_ADDR, S_RX: begin
                if (sclRise && bitCnt_reg != 4'h8) begin
                  shift_reg <= {shift_reg[6:0], sdaIn[p]};
                  bitCnt_reg <= bitCnt_reg + 1'b1;
                  if (state_reg == S_ADDR && bitCnt_reg == 4'h7 && addrHit && sdaIn[p]
                      && earlyTxReq) begin
                    txReqPulse <= 1'b1;
                  end
                end else if (sclFall && bitCnt_reg == 4'h8) begin
                  bitCnt_reg <= 4'h0;
                  if (state_reg == S_ADDR) begin
                    if (shift_reg[7:1] == ownAddr) begin
                      sdaLow_reg <= 1'b1;
                      rwBit_reg <= shift_reg[0];
                      state_reg <= S_ACK;
                      if (shift_reg[0] && !earlyTxReq) begin
                        txReqPulse <= 1'b1;
                      end
                    end else begin
                      state_reg <= S_IDLE;
                    end
                  end else begin
                    rxData_reg <= shift_reg;
                    rxDonePulse <= 1'b1;
                    sdaLow_reg <= ~forceNotAck;
                    nakUsedPulse <= forceNotAck;
                    state_reg <= S_ACK;
                  end
                end
              end
              S_ACK: begin
                if (sclFall) begin
                  if (rwBit_reg) begin
                    // first data bit goes out on the fall that ends the acknowledge
                    shift_reg <= txData;
                    sdaLow_reg <= ~txData[7];
                    bitCnt_reg <= 4'h1;
                    state_reg <= S_TX;
                  end else begin
                    sdaLow_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    state_reg <= S_RX;
                  end
                end
              end
              S_TX: begin
                if (sclFall) begin
                  if (bitCnt_reg == 4'h8) begin
                    sdaLow_reg <= 1'b0;
                    txDonePulse <= 1'b1;
                    state_reg <= S_MACK;
                  end else begin
                    sdaLow_reg <= ~shift_reg[6];
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    bitCnt_reg <= bitCnt_reg + 1'b1;
                  end
                end
              end
              S_MACK: begin
                if (sclRise) begin
                  masterAck_reg <= ~sdaIn[p];
                  txReqPulse <= ~sdaIn[p];
                end else if (sclFall) begin
                  if (masterAck_reg) begin
                    shift_reg <= txData;
                    sdaLow_reg <= ~txData[7];
                    bitCnt_reg <= 4'h1;
                    state_reg <= S_TX;
                  end else begin
                    // master ended the read; release and wait for stop or start
                    state_reg <= S_IDLE;
                  end
                end
              end
              default: begin
                state_reg <= S_IDLE;
              end
            endcase
          end
        end
      end

      always @* begin
        rdData = 32'h00000000;
        if (wb_adr_i == aDiv) begin
          rdData = {16'h0000, sclDivider_reg};
        end else if (wb_adr_i == aCtl) begin
          rdData = {16'h0000, slaveControl_reg};
        end else if (wb_adr_i == aAux) begin
          rdData = {16'h0000, slaveAux_reg};
        end else if (wb_adr_i == aSta) begin
          // engine state is visible read-only so software can spot a stuck transfer
          rdData = {16'h0000, rxData_reg, 1'b0, state_reg, flags_reg};
        end
      end
      assign rdPort[p] = rdData;
    end
  endgenerate

  // each port decodes only its own addresses, so or-ing the ports selects the one hit
  reg [31:0] rdAll;
  integer k;

  always @* begin
    rdAll = 32'h00000000;
    for (k = 0; k < NPORT; k = k + 1) begin
      rdAll = rdAll | rdPort[k];
    end
  end

  // single-cycle wait: ack one cycle after the request, read data with it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rdAll;
      end
    end
  end
endmodule // isc_ctrl_top

// ### hdl/isc_defines.vh
// register addresses, field positions and reset values for the two-wire controller pair
`ifndef ISC_DEFINES_VH
`define ISC_DEFINES_VH

`define ISC_P0_SCL_DIVIDER 32'hffff08a4
`define ISC_P0_SLAVE_CONTROL 32'hffff08a8
`define ISC_P0_SLAVE_AUX 32'hffff08ac
`define ISC_P0_SLAVE_STATUS 32'hffff08b0
`define ISC_P1_SCL_DIVIDER 32'hffff0924
`define ISC_P1_SLAVE_CONTROL 32'hffff0928
`define ISC_P1_SLAVE_AUX 32'hffff092c
`define ISC_P1_SLAVE_STATUS 32'hffff0930

`define ISC_DIV_RESET 16'h1f1f
`define ISC_SCTL_RESET 16'h0000
`define ISC_AUX_RESET 16'h0000
`define ISC_SCTL_MASK 16'h07a0

`define ISC_DIV_HIGH_MSB 15
`define ISC_DIV_HIGH_LSB 8
`define ISC_DIV_LOW_MSB 7
`define ISC_DIV_LOW_LSB 0

`define ISC_SCTL_TX_IRQ_EN 10
`define ISC_SCTL_RX_IRQ_EN 9
`define ISC_SCTL_STOP_IRQ_EN 8
`define ISC_SCTL_FORCE_NOT_ACK 7
`define ISC_SCTL_EARLY_TX_REQ 5

`define ISC_AUX_ADDR_MSB 6
`define ISC_AUX_MASTER_EN 7
`define ISC_AUX_TXDATA_MSB 15
`define ISC_AUX_TXDATA_LSB 8

`define ISC_STA_TX_DONE 0
`define ISC_STA_RX_DONE 1
`define ISC_STA_STOP 2
`define ISC_STA_TX_REQ 3

`endif

// ### hdl/isc_scl_gen.v
// master serial clock generator: counted high and low phases with clock stretching
`timescale 1ns/1ps
module isc_scl_gen #(
  parameter CW = 8
) (
  input wire clk,
  input wire rst_b,
  input wire enable,
  input wire [CW-1:0] highCount,
  input wire [CW-1:0] lowCount,
  input wire sclIn,
  output wire sclDriveLow
);
  reg [CW-1:0] cnt_reg;
  reg lowPhase_reg;

  // each phase lasts its field value plus one cycle, so a zero field never stalls
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {CW{1'b0}};
      lowPhase_reg <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= {CW{1'b0}};
      lowPhase_reg <= 1'b0;
    end else if (lowPhase_reg) begin
      if (cnt_reg == lowCount) begin
        cnt_reg <= {CW{1'b0}};
        lowPhase_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end else if (sclIn) begin
      // high time counts only once the line is really high, so a stretching slave holds it
      if (cnt_reg == highCount) begin
        cnt_reg <= {CW{1'b0}};
        lowPhase_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign sclDriveLow = enable & lowPhase_reg;
endmodule // isc_scl_gen
